// ### exc_pkg.sv
// Constants, field layouts and carrier types for the exception cause/status logic
package exc_pkg;

  // Register byte offsets
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] CAUSE_OFS = 4'h4;
  localparam logic [3:0] CORE_CFG_OFS = 4'h8;

  // Status field positions
  localparam int COPROC_USABLE_LSB = 28;
  localparam int DATA_WAY_A_LOCK_BIT = 24;
  localparam int INSTR_WAY_A_LOCK_BIT = 23;
  localparam int MASK_LSB = 8;
  localparam int USER_LEVEL_SELECT_BIT = 4;
  localparam int FAULT_LEVEL_BIT = 2;
  localparam int EXCEPTION_LEVEL_BIT = 1;
  localparam int IRQ_ENABLE_BIT = 0;
  localparam logic [31:0] STATUS_WRITABLE = 32'hf180_ff17;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0004;

  // Cause field positions
  localparam int DELAY_FLAG_BIT = 31;
  localparam int UNIT_NUMBER_LSB = 28;
  localparam int PENDING_LSB = 8;
  localparam int KIND_LSB = 2;
  localparam logic [1:0] SOFT_PENDING_RESET = 2'h0;

  // Own configuration register: bit 0 early family, bit 1 FPU present
  localparam int CFG_EARLY_BIT = 0;
  localparam int CFG_FPU_BIT = 1;
  localparam logic [31:0] CORE_CFG_RESET = 32'h0000_0002;

  // Return point step back over the branch
  localparam logic [31:0] DELAY_SLOT_STEP = 32'h0000_0004;

  // Exception kind codes
  localparam logic [4:0] INTERRUPT_CODE = 5'h00;
  localparam logic [4:0] ENTRY_MODIFY_CODE = 5'h01;
  localparam logic [4:0] TRANSLATION_LOAD_MISS_CODE = 5'h02;
  localparam logic [4:0] TRANSLATION_STORE_MISS_CODE = 5'h03;
  localparam logic [4:0] MISALIGNED_LOAD_CODE = 5'h04;
  localparam logic [4:0] MISALIGNED_STORE_CODE = 5'h05;
  localparam logic [4:0] FETCH_BUS_FAULT_CODE = 5'h06;
  localparam logic [4:0] LOAD_BUS_FAULT_CODE = 5'h07;
  localparam logic [4:0] SYSTEM_CALL_CODE = 5'h08;
  localparam logic [4:0] BREAK_CODE = 5'h09;
  localparam logic [4:0] BAD_OPCODE_CODE = 5'h0a;
  localparam logic [4:0] COPROC_UNUSABLE_CODE = 5'h0b;
  localparam logic [4:0] SUM_RANGE_FAULT_CODE = 5'h0c;
  localparam logic [4:0] CONDITIONAL_FAULT_CODE = 5'h0d;
  localparam logic [4:0] FLOAT_FAULT_CODE = 5'h0f;

  // Avalon response encodings
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECODEERROR = 2'h3;

  // Access sizes
  localparam logic [1:0] SIZE_BYTE = 2'h0;
  localparam logic [1:0] SIZE_HALF = 2'h1;
  localparam logic [1:0] SIZE_WORD = 2'h2;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_t;

  // Raw fault events from the pipeline, one cycle each
  typedef struct packed {
    logic entry_modify;
    logic translation_load_miss;
    logic translation_store_miss;
    logic fetch_bus_fault;
    logic load_bus_fault;
    logic store_bus_fault;
    logic system_call;
    logic break_instr;
    logic bad_opcode;
    logic sum_overflow;
    logic conditional_fault;
    logic float_fault;
  } exc_src_t;

  // Memory access presented for address checking
  typedef struct packed {
    logic valid;
    logic is_fetch;
    logic is_store;
    logic [1:0] size;
    logic [31:0] addr;
  } mem_access_t;

  // Qualified causes fed to the priority encoder
  typedef struct packed {
    exc_src_t src;
    logic addr_fetch;
    logic addr_load;
    logic addr_store;
    logic coproc_unusable;
    logic interrupt;
  } exc_req_t;

endpackage

// ### exc_kind_encoder.sv
// Priority encoder turning qualified exception causes into a kind code
`timescale 1ns/1ps
module exc_kind_encoder (
  input wire exc_pkg::exc_req_t req_i,
  output logic hit_o,
  output logic [4:0] code_o
);

  // Fetch-side faults first, then decode, execute, memory; interrupt last
  always_comb begin
    hit_o = 1'b1;
    code_o = exc_pkg::INTERRUPT_CODE;
    if (req_i.addr_fetch) begin
      code_o = exc_pkg::MISALIGNED_LOAD_CODE;
    end else if (req_i.src.fetch_bus_fault) begin
      code_o = exc_pkg::FETCH_BUS_FAULT_CODE;
    end else if (req_i.src.system_call) begin
      code_o = exc_pkg::SYSTEM_CALL_CODE;
    end else if (req_i.src.break_instr) begin
      code_o = exc_pkg::BREAK_CODE;
    end else if (req_i.src.bad_opcode) begin
      code_o = exc_pkg::BAD_OPCODE_CODE;
    end else if (req_i.coproc_unusable) begin
      code_o = exc_pkg::COPROC_UNUSABLE_CODE;
    end else if (req_i.src.sum_overflow) begin
      code_o = exc_pkg::SUM_RANGE_FAULT_CODE;
    end else if (req_i.src.conditional_fault) begin
      code_o = exc_pkg::CONDITIONAL_FAULT_CODE;
    end else if (req_i.src.float_fault) begin
      code_o = exc_pkg::FLOAT_FAULT_CODE;
    end else if (req_i.addr_load) begin
      code_o = exc_pkg::MISALIGNED_LOAD_CODE;
    end else if (req_i.addr_store) begin
      code_o = exc_pkg::MISALIGNED_STORE_CODE;
    end else if (req_i.src.entry_modify) begin
      code_o = exc_pkg::ENTRY_MODIFY_CODE;
    end else if (req_i.src.translation_load_miss) begin
      code_o = exc_pkg::TRANSLATION_LOAD_MISS_CODE;
    end else if (req_i.src.translation_store_miss) begin
      code_o = exc_pkg::TRANSLATION_STORE_MISS_CODE;
    end else if (req_i.src.load_bus_fault || req_i.src.store_bus_fault) begin
      code_o = exc_pkg::LOAD_BUS_FAULT_CODE;
    end else if (req_i.interrupt) begin
      code_o = exc_pkg::INTERRUPT_CODE;
    end else begin
      hit_o = 1'b0;
    end
  end

endmodule

// ### exception_cause_status_logic.sv
// Status/cause registers, exception capture and interrupt decision of the core
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
module exception_cause_status_logic (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic [5:0] int_pins_i,
  input wire exc_pkg::exc_src_t exc_src_i,
  input wire logic arith_unsigned_i,
  input wire logic cop_instr_i,
  input wire logic [1:0] cop_number_i,
  input wire exc_pkg::mem_access_t mem_access_i,
  input wire logic in_delay_slot_i,
  input wire logic [31:0] fault_pc_i,
  input wire logic dcache_refill_req_i,
  input wire logic dcache_way_a_valid_i,
  input wire logic dcache_victim_i,
  input wire logic dcache_store_i,
  input wire logic icache_refill_req_i,
  input wire logic icache_way_a_valid_i,
  input wire logic icache_victim_i,
  output logic exc_taken_o,
  output logic [4:0] exc_kind_o,
  output logic [31:0] return_point_o,
  output logic interrupt_request_o,
  output logic user_mode_o,
  output logic dcache_refill_go_o,
  output logic dcache_refill_way_o,
  output logic dcache_store_update_o,
  output logic icache_refill_go_o,
  output logic icache_refill_way_o
);

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0] lanes);
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (lanes[b]) begin
        res[8*b +: 8] = new_val[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Way chosen for a refill when way A is locked
  function automatic logic pick_way(input logic lock,
                                    input logic way_a_valid,
                                    input logic victim);
    return (lock && way_a_valid) ? 1'b1 : victim;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // State

  exc_pkg::bus_state_t bus_state;
  exc_pkg::bus_state_t next_bus_state;
  logic [31:0] status;
  logic [31:0] core_cfg;
  logic [1:0] soft_pending;
  logic delay_flag;
  logic [1:0] unit_number;
  logic [4:0] kind_field;

  //////////////////////////////////////////////////////////////////////////////
  // Status decode

  wire logic irq_enable = status[exc_pkg::IRQ_ENABLE_BIT];
  wire logic exception_level = status[exc_pkg::EXCEPTION_LEVEL_BIT];
  wire logic fault_level = status[exc_pkg::FAULT_LEVEL_BIT];
  wire logic user_level_select = status[exc_pkg::USER_LEVEL_SELECT_BIT];
  wire logic data_way_a_lock = status[exc_pkg::DATA_WAY_A_LOCK_BIT];
  wire logic instr_way_a_lock = status[exc_pkg::INSTR_WAY_A_LOCK_BIT];
  wire logic [7:0] interrupt_mask_bits = status[exc_pkg::MASK_LSB +: 8];
  wire logic [3:0] coproc_usable_bits = status[exc_pkg::COPROC_USABLE_LSB +: 4];
  wire logic early_family = core_cfg[exc_pkg::CFG_EARLY_BIT];
  wire logic fpu_present = core_cfg[exc_pkg::CFG_FPU_BIT];

  // Either level forces kernel mode whatever the select bit says
  wire logic user_mode = user_level_select && !exception_level && !fault_level;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt decision

  // Hardware lines are live pins, never latched
  wire logic [7:0] pending_interrupt_lines = {int_pins_i, soft_pending};
  wire logic irq_allowed = irq_enable && !exception_level && !fault_level;
  wire logic irq_now = irq_allowed && |(pending_interrupt_lines & interrupt_mask_bits);

  //////////////////////////////////////////////////////////////////////////////
  // Address error checks

  wire logic half_misaligned = (mem_access_i.size == exc_pkg::SIZE_HALF) &&
                               mem_access_i.addr[0];
  wire logic word_misaligned = (mem_access_i.size == exc_pkg::SIZE_WORD) &&
                               (mem_access_i.addr[1:0] != 2'h0);
  // Top half of the address space is out of bounds for user code
  wire logic outside_user = user_mode && mem_access_i.addr[31];
  wire logic addr_fault = mem_access_i.valid &&
                          (half_misaligned || word_misaligned || outside_user);

  //////////////////////////////////////////////////////////////////////////////
  // Cause qualification

  wire logic coproc_unusable = cop_instr_i && !coproc_usable_bits[cop_number_i];
  exc_pkg::exc_src_t src_q;
  exc_pkg::exc_req_t req;

  // Gate causes the selected core variant cannot produce, and overflow on unsigned arithmetic
  always_comb begin
    src_q = exc_src_i;
    src_q.store_bus_fault = exc_src_i.store_bus_fault && !early_family;
    src_q.sum_overflow = exc_src_i.sum_overflow && !arith_unsigned_i;
    src_q.conditional_fault = exc_src_i.conditional_fault && !early_family;
    src_q.float_fault = exc_src_i.float_fault && fpu_present;
  end

  assign req.src = src_q;
  assign req.addr_fetch = addr_fault && mem_access_i.is_fetch;
  assign req.addr_load = addr_fault && !mem_access_i.is_fetch && !mem_access_i.is_store;
  assign req.addr_store = addr_fault && !mem_access_i.is_fetch && mem_access_i.is_store;
  assign req.coproc_unusable = coproc_unusable;
  assign req.interrupt = irq_now;

  wire logic exc_hit;
  wire logic [4:0] exc_code;

  // Only defined codes come out, never 14 or 16 upward
  exc_kind_encoder u_encoder (
    .req_i(req),
    .hit_o(exc_hit),
    .code_o(exc_code)
  );

  // Branch before the delay slot becomes the return point
  wire logic [31:0] next_return_point = in_delay_slot_i ?
                                        fault_pc_i - exc_pkg::DELAY_SLOT_STEP :
                                        fault_pc_i;

  //////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  wire logic bus_req = avs_read_i || avs_write_i;
  wire logic sel_status = (avs_address_i == exc_pkg::STATUS_OFS);
  wire logic sel_cause = (avs_address_i == exc_pkg::CAUSE_OFS);
  wire logic sel_cfg = (avs_address_i == exc_pkg::CORE_CFG_OFS);
  wire logic mapped = sel_status || sel_cause || sel_cfg;
  // A write lands only on the edge where waitrequest is seen low
  wire logic wr_commit = avs_write_i && (bus_state == exc_pkg::BUS_ANSWER);
  wire logic wr_status = wr_commit && sel_status;
  wire logic wr_cause = wr_commit && sel_cause;
  wire logic wr_cfg = wr_commit && sel_cfg;

  // Reserved status bits 7, 6, 5, 3 are masked out and read as zero
  wire logic [31:0] status_view = status & exc_pkg::STATUS_WRITABLE;
  // Pending field is assembled at read time from live sources
  wire logic [31:0] cause_view = {delay_flag, 1'b0, unit_number, 12'h000,
                                  pending_interrupt_lines, 1'b0, kind_field,
                                  2'h0};

  logic [31:0] read_word;

  // Address decoding of read data, unmapped returns zero
  always_comb begin
    if (sel_status) begin
      read_word = status_view;
    end else if (sel_cause) begin
      read_word = cause_view;
    end else if (sel_cfg) begin
      read_word = core_cfg;
    end else begin
      read_word = 32'h0000_0000;
    end
  end

  wire logic [31:0] merged_status = merge_bytes(status, avs_writedata_i, avs_byteenable_i) &
                                    exc_pkg::STATUS_WRITABLE;
  wire logic [31:0] merged_cause = merge_bytes(cause_view, avs_writedata_i,
                                               avs_byteenable_i);
  wire logic [31:0] merged_cfg = merge_bytes(core_cfg, avs_writedata_i, avs_byteenable_i);

  //////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, answer on the second

  always_comb begin
    case (bus_state)
      exc_pkg::BUS_IDLE: begin
        next_bus_state = bus_req ? exc_pkg::BUS_ANSWER : exc_pkg::BUS_IDLE;
      end
      exc_pkg::BUS_ANSWER: begin
        next_bus_state = exc_pkg::BUS_IDLE;
      end
      default: begin
        next_bus_state = exc_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state <= exc_pkg::BUS_IDLE;
    end else begin
      bus_state <= next_bus_state;
    end
  end

  // Waitrequest idles high; it drops for exactly the answering cycle
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= !(next_bus_state == exc_pkg::BUS_ANSWER);
    end
  end

  // Read data and response captured as the answer cycle opens
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_readdata_o <= 32'h0000_0000;
      avs_response_o <= exc_pkg::RESP_OKAY;
    end else if (bus_state == exc_pkg::BUS_IDLE && bus_req) begin
      avs_readdata_o <= avs_read_i ? read_word : 32'h0000_0000;
      avs_response_o <= mapped ? exc_pkg::RESP_OKAY : exc_pkg::RESP_DECODEERROR;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status register; exception entry raises the exception level

  // Entry and a software write in the same cycle both land; entry forces the exception level on
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status <= exc_pkg::STATUS_RESET;
    end else if (exc_hit) begin
      status <= (wr_status ? merged_status : status) |
                (32'h0000_0001 << exc_pkg::EXCEPTION_LEVEL_BIT);
    end else if (wr_status) begin
      status <= merged_status;
    end
  end

  // Variant selection, software owned
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      core_cfg <= exc_pkg::CORE_CFG_RESET;
    end else if (wr_cfg) begin
      core_cfg <= merged_cfg & 32'h0000_0003;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cause register

  // Software pending bits hold the last value written
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_pending <= exc_pkg::SOFT_PENDING_RESET;
    end else if (wr_cause) begin
      soft_pending <= merged_cause[exc_pkg::PENDING_LSB +: 2];
    end
  end

  // Snapshot fields update at entry (unit number only when coproc_unusable is set, whichever kind wins) and hold otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      delay_flag <= 1'b0;
      unit_number <= 2'h0;
      kind_field <= exc_pkg::INTERRUPT_CODE;
    end else if (exc_hit) begin
      delay_flag <= in_delay_slot_i;
      // Unit number is meaningful only for unusable-coprocessor entries
      unit_number <= coproc_unusable ? cop_number_i : unit_number;
      kind_field <= exc_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pipeline-facing outputs

  // One-cycle entry pulse with its code and return point
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      exc_taken_o <= 1'b0;
      exc_kind_o <= exc_pkg::INTERRUPT_CODE;
      return_point_o <= 32'h0000_0000;
    end else begin
      exc_taken_o <= exc_hit;
      if (exc_hit) begin
        exc_kind_o <= exc_code;
        return_point_o <= next_return_point;
      end
    end
  end

  // Registered mode and interrupt level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      interrupt_request_o <= 1'b0;
      user_mode_o <= 1'b0;
    end else begin
      interrupt_request_o <= irq_now;
      user_mode_o <= user_mode;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Cache way-A locking; costs one cycle of refill latency

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      dcache_refill_go_o <= 1'b0;
      dcache_refill_way_o <= 1'b0;
      dcache_store_update_o <= 1'b0;
    end else begin
      dcache_refill_go_o <= dcache_refill_req_i;
      dcache_refill_way_o <= pick_way(data_way_a_lock, dcache_way_a_valid_i,
                                      dcache_victim_i);
      // Stores keep updating the cache even when locked
      dcache_store_update_o <= dcache_store_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      icache_refill_go_o <= 1'b0;
      icache_refill_way_o <= 1'b0;
    end else begin
      icache_refill_go_o <= icache_refill_req_i;
      icache_refill_way_o <= pick_way(instr_way_a_lock, icache_way_a_valid_i,
                                      icache_victim_i);
    end
  end

endmodule

// ### exception_cause_status_logic_props.sv
// Port-level checks for the exception cause and status block
`timescale 1ns/1ps
module exception_cause_status_logic_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [5:0] int_pins_i,
  input wire exc_pkg::exc_src_t exc_src_i,
  input wire exc_pkg::mem_access_t mem_access_i,
  input wire logic in_delay_slot_i,
  input wire logic [31:0] fault_pc_i,
  input wire logic icache_refill_req_i,
  input wire logic icache_way_a_valid_i,
  input wire logic icache_victim_i,
  input wire logic icache_refill_way_o,
  input wire logic exc_taken_o,
  input wire logic [4:0] exc_kind_o,
  input wire logic [31:0] return_point_o,
  input wire logic interrupt_request_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Lone system call: nothing of higher priority can mask it
  wire sole_call = exc_src_i.system_call && !exc_src_i.fetch_bus_fault && !mem_access_i.valid;
  wire idle_rd = avs_read_i && avs_waitrequest_o;
  one_wait_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer not one cycle");
  live_pins_a: assert property (
    idle_rd && avs_address_i == exc_pkg::CAUSE_OFS |=> avs_readdata_o[15:10] == $past(int_pins_i))
    else $error("pending field not live");
  reserved_zero_a: assert property (
    idle_rd && avs_address_i == exc_pkg::STATUS_OFS |=> avs_readdata_o[7:6] == 2'h0
    && !avs_readdata_o[3]) else $error("reserved status bits not zero");
  call_code_a: assert property (sole_call |=> exc_taken_o && exc_kind_o == 5'h08)
    else $error("system call code wrong");
  slot_point_a: assert property (
    sole_call && in_delay_slot_i |=> return_point_o == $past(fault_pc_i) - 32'h4)
    else $error("delay slot return point wrong");
  kind_hold_a: assert property (
    !exc_taken_o |-> $stable(exc_kind_o) && $stable(return_point_o))
    else $error("snapshot changed without entry");
  legal_code_a: assert property (exc_taken_o |-> exc_kind_o != 5'h0e && exc_kind_o < 5'h10)
    else $error("reserved code produced");
  irq_blocked_a: assert property (exc_taken_o |=> !interrupt_request_o)
    else $error("interrupt requested at exception level");
  way_invalid_a: assert property (
    icache_refill_req_i && !icache_way_a_valid_i |=> icache_refill_way_o == $past(icache_victim_i))
    else $error("refill kept off an invalid way");
endmodule
////////////////////////////////////////////////////////////////
bind exception_cause_status_logic exception_cause_status_logic_props props (.*);

// ### exception_cause_status_logic_tb_top.sv
// Self-checking bench for the exception cause and status block
`timescale 1ns/1ps
module exception_cause_status_logic_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, avs_read_i = 1'b0, avs_write_i = 1'b0;
  logic [3:0] avs_address_i = 4'h0, avs_byteenable_i = 4'hf;
  logic [31:0] avs_writedata_i = 32'h0, fault_pc_i = 32'h0, avs_readdata_o, return_point_o;
  logic [31:0] q, rp, r, seed = 32'h0000_c3a2;
  logic [5:0] int_pins_i = 6'h0;
  exc_pkg::exc_src_t exc_src_i = '0;
  exc_pkg::mem_access_t mem_access_i = '0;
  logic arith_unsigned_i = 1'b0, cop_instr_i = 1'b0, in_delay_slot_i = 1'b0;
  logic [1:0] cop_number_i = 2'h0, avs_response_o;
  logic dcache_refill_req_i = 1'b0, dcache_way_a_valid_i = 1'b0, dcache_victim_i = 1'b0;
  logic dcache_store_i = 1'b0, icache_refill_req_i = 1'b0, icache_way_a_valid_i = 1'b0;
  logic icache_victim_i = 1'b0, avs_waitrequest_o, exc_taken_o, interrupt_request_o, user_mode_o;
  logic dcache_refill_go_o, dcache_refill_way_o, dcache_store_update_o, icache_refill_go_o;
  logic icache_refill_way_o;
  logic [4:0] exc_kind_o;
  int num_errors = 0, checked = 0;

  exception_cause_status_logic DUT (.*);

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////
  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Expected {taken, code} for source bit i, MSB first
  function automatic logic [5:0] expect_kind(input int i, input logic early, input logic uns);
    logic [4:0] t [12] = '{5'h01, 5'h02, 5'h03, 5'h06, 5'h07, 5'h07, 5'h08, 5'h09, 5'h0a,
                           5'h0c, 5'h0d, 5'h0f};
    if ((i == 5 || i == 10) && early) return 6'h00;
    if ((i == 11 && early) || (i == 9 && uns)) return 6'h00;
    return {1'b1, t[i]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low; read data taken at that edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    // No cycle count assumed; a stalled slave is left to the watchdog
    do begin
      @(posedge clk_i);
    end while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask

  // One fault cycle with random pc, slot, pins; then entry and cause snapshot
  task automatic fire(input exc_pkg::exc_src_t s, input logic c, input exc_pkg::mem_access_t m,
                      input logic u, input logic [5:0] e);
    logic [31:0] pc;
    logic [1:0] cn;
    logic [4:0] kd;
    pc = rnd();
    cn = (pc[5:4] == 2'h0) ? 2'h2 : pc[5:4];
    @(posedge clk_i);
    rp = return_point_o;
    kd = exc_kind_o;
    exc_src_i <= s;
    cop_instr_i <= c;
    cop_number_i <= cn;
    mem_access_i <= m;
    arith_unsigned_i <= u;
    in_delay_slot_i <= pc[0];
    fault_pc_i <= pc;
    int_pins_i <= pc[11:6];
    @(posedge clk_i);
    exc_src_i <= '0;
    cop_instr_i <= 1'b0;
    mem_access_i <= '0;
    #1;
    check(exc_taken_o, e[5], "taken");
    check(exc_kind_o, e[5] ? e[4:0] : kd, "kind");
    check(return_point_o, e[5] ? pc - {29'h0, pc[0], 2'h0} : rp, "return point");
    bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
    check(q[15:10], int_pins_i, "pending pins");
    if (e[5]) check({q[31], q[6:2]}, {pc[0], e[4:0]}, "cause snapshot");
    if (c) check(q[29:28], cn, "unit number");
  endtask

  // Bounded wait for an interrupt entry
  task automatic await_irq();
    int n = 0;
    do begin
      @(posedge clk_i);
      #1;
      n++;
    end while (exc_taken_o !== 1'b1 && n < 8);
    check(exc_taken_o, 1'b1, "irq taken");
    check(interrupt_request_o, 1'b1, "irq request");
    check(exc_kind_o, exc_pkg::INTERRUPT_CODE, "irq kind");
  endtask

  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, exc_pkg::STATUS_OFS, 32'h0);
    check(q, exc_pkg::STATUS_RESET, "status reset");
    check(avs_response_o, exc_pkg::RESP_OKAY, "mapped response");
    bus(1'b0, 4'hc, 32'h0);
    check(q, 32'h0, "unmapped data");
    check(avs_response_o, exc_pkg::RESP_DECODEERROR, "unmapped response");
    $display("test reset done");
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, exc_pkg::CORE_CFG_OFS, (k == 1) ? 32'h1 : 32'h2);
      for (int i = 0; i < 12; i++) begin
        r = rnd();
        fire(exc_pkg::exc_src_t'(12'h800 >> i), 1'b0, '0, r[0], expect_kind(i, k == 1, r[0]));
      end
    end
    $display("test codes done");
    fire('0, 1'b1, '0, 1'b0, {1'b1, exc_pkg::COPROC_UNUSABLE_CODE});
    fire('0, 1'b0, {3'b100, exc_pkg::SIZE_WORD, 32'h0000_0102}, 1'b0, 6'h24);
    fire('0, 1'b0, {3'b101, exc_pkg::SIZE_HALF, 32'h0000_0101}, 1'b0, 6'h25);
    fire('0, 1'b0, {3'b110, exc_pkg::SIZE_WORD, 32'h0000_0001}, 1'b0, 6'h24);
    fire('0, 1'b0, {3'b100, exc_pkg::SIZE_BYTE, 32'h0000_0003}, 1'b0, 6'h00);
    bus(1'b1, exc_pkg::STATUS_OFS, 32'h0000_0010);
    @(posedge clk_i);
    #1;
    check(user_mode_o, 1'b1, "user mode");
    fire('0, 1'b0, {3'b100, exc_pkg::SIZE_WORD, 32'h8000_0000}, 1'b0, 6'h24);
    check(user_mode_o, 1'b0, "kernel at exception level");
    $display("test address done");
    @(posedge clk_i);
    int_pins_i <= 6'h01;
    bus(1'b1, exc_pkg::STATUS_OFS, 32'h0000_0401);
    await_irq();
    bus(1'b1, exc_pkg::STATUS_OFS, 32'h0000_0101);
    bus(1'b1, exc_pkg::CAUSE_OFS, 32'h0000_0100);
    await_irq();
    bus(1'b0, exc_pkg::CAUSE_OFS, 32'h0);
    check(q[9:8], 2'h1, "soft pending");
    $display("test interrupts done");
    bus(1'b1, exc_pkg::STATUS_OFS, 32'h0180_0002);
    @(posedge clk_i);
    {dcache_refill_req_i, dcache_way_a_valid_i, dcache_store_i} <= 3'h7;
    {icache_refill_req_i, icache_way_a_valid_i} <= 2'h3;
    @(posedge clk_i);
    #1;
    check({dcache_refill_go_o, dcache_refill_way_o, icache_refill_go_o, icache_refill_way_o,
           dcache_store_update_o}, 5'h1f, "locked refill");
    @(posedge clk_i);
    dcache_way_a_valid_i <= 1'b0;
    {icache_way_a_valid_i, icache_victim_i} <= 2'h1;
    @(posedge clk_i);
    #1;
    check({dcache_refill_way_o, icache_refill_way_o, dcache_store_update_o}, 3'h3,
          "invalid way");
    bus(1'b1, exc_pkg::STATUS_OFS, 32'hffff_ffff);
    bus(1'b0, exc_pkg::STATUS_OFS, 32'h0);
    check(q, exc_pkg::STATUS_WRITABLE, "status mask");
    // Only the enabled lane of a partial write may change
    avs_byteenable_i <= 4'h1;
    bus(1'b1, exc_pkg::STATUS_OFS, 32'h0);
    avs_byteenable_i <= 4'hf;
    bus(1'b0, exc_pkg::STATUS_OFS, 32'h0);
    check(q, exc_pkg::STATUS_WRITABLE & 32'hffff_ff00, "status byte lane");
    $display("test locks done");
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the tests need
  initial begin
    #50000;
    num_errors++;
    summarize();
  end
endmodule
